// >>> testbench/alias_remap_sva.sv
module alias_remap_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_oe_n_o,
  input wire alias_remap_pkg::fwd_t fwd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // forwarding and bus answer checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  start_pulse_a: assert property (fwd_o.start |=> !fwd_o.start) else $error("start not one cycle");
  addr_hold_a: assert property (!fwd_o.start |-> $stable(fwd_o.addr)) else $error("addr moved");
  addr_nonzero_a: assert property (fwd_o.start |-> fwd_o.addr != 7'h00) else $error("zero addr sent");
  rw_hold_a: assert property (!fwd_o.start |-> $stable(fwd_o.rw)) else $error("rw moved");
  data_write_a: assert property (fwd_o.data_valid |-> !fwd_o.rw) else $error("data on read");
  data_gap_a: assert property (fwd_o.data_valid |=> !fwd_o.data_valid [*8]) else $error("data too close");
  // the answer may only move while scl is low, else it reads as start or stop
  ack_scl_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("sda moved, scl high");
  stop_scl_high_a: assert property (fwd_o.stop |-> scl_i) else $error("stop with scl low");
endmodule : alias_remap_sva

bind i2c_alias_remap_status alias_remap_sva u_sva (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_oe_n_o(sda_oe_n_o),
  .fwd_o(fwd_o)
);

// >>> testbench/i2c_host_model.sv
module i2c_host_model (
  input wire logic clk_i,
  input wire logic dev_sda_i,
  input wire logic dev_oe_n_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_q = 1'b1;
  // ----------------------------------------------------------------
  // wired-and bus, pull-up when nobody pulls low
  // ----------------------------------------------------------------
  assign sda_o = drv_q & (dev_oe_n_i | dev_sda_i);
  initial scl_o = 1'b1;

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // start (stp 0) or stop (stp 1); sda is set while scl is low, then moves again with scl high
  task cond(input logic stp);
    cyc(6);
    drv_q <= !stp;
    cyc(6);
    scl_o <= 1'b1;
    cyc(12);
    drv_q <= stp;
    cyc(12);
    if (!stp) scl_o <= 1'b0;
  endtask : cond

  // one bit per 25 cycles (125 ns): sda set mid-low, sampled mid-high
  task xbit(input logic b, output logic r);
    cyc(6);
    drv_q <= b;
    cyc(6);
    scl_o <= 1'b1;
    cyc(7);
    r = sda_o;
    cyc(6);
    scl_o <= 1'b0;
  endtask : xbit

  // eight bits msb first, then the ack slot (last 1 releases the line)
  task xbyte(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack_n);
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(last, ack_n);
  endtask : xbyte
endmodule : i2c_host_model

// >>> testbench/testbench.sv
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] REV = 3'h5;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl, sda, sda_o, sda_oe_n_o, ak, nk, f_rw;
  logic bc_err, rem_err, id_load;
  logic [6:0] remote_id, f_addr;
  logic [7:0] rdata;
  logic [7:0] rv, rx, rb, f_data;
  logic [7:0] offs [5] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
  logic [3:0] pats [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
  alias_remap_pkg::status_in_t status_i;
  alias_remap_pkg::fwd_t fwd_o;
  int err_total = 0;
  int cmp_count = 0;
  int n_stop = 0;

  always #2.5 clk_i = ~clk_i;

  i2c_alias_remap_status #(.LOCAL_ADDR(7'h0c), .REVISION(REV)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .status_i(status_i),
    .backchannel_crc_err_i(bc_err), .remote_crc_err_i(rem_err), .remote_id_load_i(id_load),
    .remote_id_i(remote_id), .remote_rdata_i(rdata), .fwd_o(fwd_o));
  i2c_host_model u_host (.clk_i(clk_i), .dev_sda_i(sda_o), .dev_oe_n_i(sda_oe_n_o), .scl_o(scl), .sda_o(sda));

  // ----------------------------------------------------------------
  // capture of forwarded traffic
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin // mid-cycle, away from the edge that launches the pulses
    if (fwd_o.start === 1'b1) f_addr = fwd_o.addr;
    if (fwd_o.start === 1'b1) f_rw = fwd_o.rw;
    if (fwd_o.data_valid === 1'b1) f_data = fwd_o.data;
    if (fwd_o.stop === 1'b1) n_stop++;
  end

  task stop_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task reg_wr(input logic [7:0] off, input logic [7:0] v);
    u_host.cond(1'b0);
    u_host.xbyte({7'h0c, 1'b0}, 1'b1, rv, ak);
    u_host.xbyte(off, 1'b1, rv, ak);
    u_host.xbyte(v, 1'b1, rv, ak);
    u_host.cond(1'b1);
  endtask : reg_wr

  // pointer write, repeated start, one byte read with nack
  task rd_chk(input string n, input logic [7:0] off, input logic [7:0] e);
    u_host.cond(1'b0);
    u_host.xbyte({7'h0c, 1'b0}, 1'b1, rv, ak);
    u_host.xbyte(off, 1'b1, rv, ak);
    u_host.cond(1'b0);
    u_host.xbyte({7'h0c, 1'b1}, 1'b1, rv, ak);
    u_host.xbyte(8'hff, 1'b1, rb, nk);
    u_host.cond(1'b1);
    `CHK(n, e, rb)
  endtask : rd_chk

  // single byte transaction to a remote address
  task tx(input logic [6:0] a, input logic rw, input logic [7:0] d);
    u_host.cond(1'b0);
    u_host.xbyte({a, rw}, 1'b1, rv, ak);
    u_host.xbyte(rw ? 8'hff : d, 1'b1, rx, nk);
    u_host.cond(1'b1);
  endtask : tx

  // k: 0 back-channel crc, 1 remote crc, 2 id load
  task pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      bc_err <= (k == 0);
      rem_err <= (k == 1);
      id_load <= (k == 2);
      @(posedge clk_i);
      {bc_err, rem_err, id_load} <= 3'b000;
    end
  endtask : pulse

  // hang guard: a run that never ends counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {bc_err, rem_err, id_load} <= 3'b000;
    remote_id <= 7'h00;
    rdata <= 8'h00;
    status_i <= '0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    foreach (offs[i]) rd_chk("reset value", offs[i], 8'h00);
    foreach (pats[i]) begin
      status_i <= alias_remap_pkg::status_in_t'(pats[i]);
      rd_chk("status", 8'h0c, {REV, pats[i][3:1], 1'b0, pats[i][0]});
    end
    status_i <= alias_remap_pkg::status_in_t'(4'h1);
    pulse(1, 1);
    rd_chk("remote err set", 8'h0c, {REV, 5'h03});
    reg_wr(8'h03, 8'h20);
    rd_chk("remote err clr", 8'h0c, {REV, 5'h01});
    reg_wr(8'h03, 8'h00);
    pulse(1, 1);
    status_i <= alias_remap_pkg::status_in_t'(4'h0);
    rd_chk("remote err link", 8'h0c, {REV, 5'h00});
    // 257 errors cross into the high byte; writes to the count are dropped
    pulse(0, 257);
    reg_wr(8'h0a, 8'hff);
    rd_chk("count low", 8'h0a, 8'h01);
    rd_chk("count high", 8'h0b, 8'h01);
    reg_wr(8'h03, 8'h20);
    pulse(0, 2);
    rd_chk("count held", 8'h0a, 8'h00);
    rd_chk("count held hi", 8'h0b, 8'h00);
    reg_wr(8'h03, 8'h00);
    pulse(0, 1);
    rd_chk("count resumed", 8'h0a, 8'h01);
    status_i <= alias_remap_pkg::status_in_t'(4'h9);
    remote_id <= 7'h2a;
    pulse(2, 1);
    rd_chk("id loaded", 8'h06, 8'h54);
    reg_wr(8'h06, 8'h55);
    remote_id <= 7'h3c;
    pulse(2, 1);
    rd_chk("id held", 8'h06, 8'h55);
    reg_wr(8'h07, 8'h40);
    tx(7'h20, 1'b0, 8'h5a);
    `CHK("deser alias ack", 1'b0, ak)
    `CHK("deser fwd addr", 7'h2a, f_addr)
    `CHK("deser fwd rw", 1'b0, f_rw)
    `CHK("deser fwd data", 8'h5a, f_data)
    `CHK("deser fwd stop", 1, n_stop)
    reg_wr(8'h08, 8'h66);
    reg_wr(8'h09, 8'h43);
    rd_chk("target alias", 8'h09, 8'h42);
    rdata <= 8'hc3;
    tx(7'h21, 1'b1, 8'h00);
    `CHK("target read", 8'hc3, rx)
    `CHK("target fwd addr", 7'h33, f_addr)
    `CHK("target fwd rw", 1'b1, f_rw)
    reg_wr(8'h08, 8'h00);
    tx(7'h21, 1'b1, 8'h00);
    `CHK("zero id nack", 1'b1, ak)
    reg_wr(8'h07, 8'h00);
    tx(7'h20, 1'b0, 8'h5a);
    `CHK("zero alias nack", 1'b1, ak)
    `CHK("no fwd when blocked", 2, n_stop)
    stop_test();
  end
endmodule : testbench

// >>> verilog/alias_remap_pkg.sv
package alias_remap_pkg;

  // ----------------------------------------------------------------
  // register offsets on the control bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h03;
  localparam logic [7:0] OFF_DESER_ID = 8'h06;
  localparam logic [7:0] OFF_DESER_ALIAS = 8'h07;
  localparam logic [7:0] OFF_TARGET_ID = 8'h08;
  localparam logic [7:0] OFF_TARGET_ALIAS = 8'h09;
  localparam logic [7:0] OFF_CRC_LOW = 8'h0a;
  localparam logic [7:0] OFF_CRC_HIGH = 8'h0b;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CRC_CLR_BIT = 5;
  localparam int HOLD_ID_BIT = 0;
  localparam int ST_LOCK_BIT = 4;
  localparam int ST_SELFTEST_BIT = 3;
  localparam int ST_SCK_BIT = 2;
  localparam int ST_REMOTE_ERR_BIT = 1;
  localparam int ST_LINK_BIT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [6:0] ADDR_NONE = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // live status levels from the rest of the serializer (same clock)
  typedef struct packed {
    logic rx_lock;
    logic selftest_crc;
    logic sck_valid;
    logic link_detect;
  } status_in_t;

  // transaction forwarded onto the control channel
  typedef struct packed {
    logic start;
    logic [6:0] addr;
    logic rw;
    logic data_valid;
    logic [7:0] data;
    logic stop;
  } fwd_t;

  typedef enum logic [1:0] {
    DEST_LOCAL,
    DEST_DESER,
    DEST_TARGET,
    DEST_NONE
  } dest_t;

endpackage : alias_remap_pkg

// >>> verilog/i2c_alias_remap_status.sv
// Overview of operation
// [RL1] transactions to the deserializer alias are remapped to the stored deserializer identifier
// [RL2] a zero alias or zero identifier blocks access to that remote party
// [RL3] transactions to the target alias are remapped to the stored target identifier
// [RL4] remapped target transactions go over the control channel to the remote deserializer
// [RL5] sixteen-bit back-channel crc error count, low byte then high byte, resets zero
// [RL6] status bit 4 shows receive lock
// [RL7] status bit 3 shows crc errors seen during self-test
// [RL8] status bit 2 shows a valid system clock
// [RL9] status bit 1 sets on crc error talking to the remote deserializer
// [RL10] remote error bit clears on link loss or crc clear control bit
// [RL11] status bit 0 shows cable link detected
// [RL12] deserializer identifier auto-loads after lock unless the hold bit is set
// [RL13] crc clear bit holds counters cleared until software writes it back to zero
// [RL14] alias match ignores the read/write bit and forwarding keeps the direction
module i2c_alias_remap_status #(
  parameter logic [6:0] LOCAL_ADDR = 7'h0c,
  parameter logic [2:0] REVISION = 3'h1 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire alias_remap_pkg::status_in_t status_i,
  input wire logic backchannel_crc_err_i,
  input wire logic remote_crc_err_i,
  input wire logic remote_id_load_i,
  input wire logic [6:0] remote_id_i,
  input wire logic [7:0] remote_rdata_i,
  output alias_remap_pkg::fwd_t fwd_o
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WR_BYTE,
    S_WR_ACK,
    S_RD_BYTE,
    S_RD_ACK
  } bus_state_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    bus_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    alias_remap_pkg::dest_t dest;
    logic ptr_loaded;
    logic [7:0] ptr;
    logic drive_low;
    logic sda_out;
    logic [7:0] ctrl;
    logic [7:0] deser_id;
    logic [7:0] deser_alias;
    logic [7:0] target_id;
    logic [7:0] target_alias;
    logic [15:0] crc_count;
    logic remote_err;
    alias_remap_pkg::fwd_t fwd;
  } state_t;

  state_t q, d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // an alias only answers when both alias and identifier are non-zero
  function automatic logic alias_hit(input logic [6:0] addr, input logic [7:0] alias_r, input logic [7:0] id_r);
    alias_hit = (alias_r[7:1] != alias_remap_pkg::ADDR_NONE) && (id_r[7:1] != alias_remap_pkg::ADDR_NONE) &&
      (addr == alias_r[7:1]); // RL2
  endfunction : alias_hit

  function automatic logic [7:0] status_byte(input state_t s, input alias_remap_pkg::status_in_t st);
    logic [7:0] b;
    b = {REVISION, 5'h00};
    b[alias_remap_pkg::ST_LOCK_BIT] = st.rx_lock; // RL6
    b[alias_remap_pkg::ST_SELFTEST_BIT] = st.selftest_crc; // RL7
    b[alias_remap_pkg::ST_SCK_BIT] = st.sck_valid; // RL8
    b[alias_remap_pkg::ST_REMOTE_ERR_BIT] = s.remote_err; // RL9
    b[alias_remap_pkg::ST_LINK_BIT] = st.link_detect; // RL11
    status_byte = b;
  endfunction : status_byte

  function automatic logic [7:0] reg_read(input state_t s, input alias_remap_pkg::status_in_t st);
    case (s.ptr)
      alias_remap_pkg::OFF_CTRL: reg_read = s.ctrl;
      alias_remap_pkg::OFF_DESER_ID: reg_read = s.deser_id;
      alias_remap_pkg::OFF_DESER_ALIAS: reg_read = {s.deser_alias[7:1], 1'b0};
      alias_remap_pkg::OFF_TARGET_ID: reg_read = {s.target_id[7:1], 1'b0};
      alias_remap_pkg::OFF_TARGET_ALIAS: reg_read = {s.target_alias[7:1], 1'b0};
      alias_remap_pkg::OFF_CRC_LOW: reg_read = s.crc_count[7:0]; // RL5
      alias_remap_pkg::OFF_CRC_HIGH: reg_read = s.crc_count[15:8]; // RL5
      alias_remap_pkg::OFF_STATUS: reg_read = status_byte(s, st);
      default: reg_read = alias_remap_pkg::RST_BYTE;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // edges are taken only between the second and third sampling stages
  always_comb begin
    scl_rise = q.scl_s & ~q.scl_p;
    scl_fall = ~q.scl_s & q.scl_p;
    start_cond = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop_cond = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  end

  // one combinational pass over the whole block state
  always_comb begin
    d = q;
    d.scl_m = scl_i;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.fwd.start = 1'b0;
    d.fwd.data_valid = 1'b0;
    d.fwd.stop = 1'b0;

    // bus framing: start and stop override any byte in progress
    // a nacked forwarded read already sits in idle, so only dest decides the stop pulse
    if (start_cond) begin
      if (q.dest inside {alias_remap_pkg::DEST_DESER, alias_remap_pkg::DEST_TARGET}) begin
        d.fwd.stop = 1'b1; // repeated start ends the forwarded segment
      end
      d.st = S_ADDR;
      d.dest = alias_remap_pkg::DEST_NONE; // no second stop before the next address
      d.bit_cnt = 4'h0;
      d.drive_low = 1'b0;
    end else if (stop_cond) begin
      if (q.dest inside {alias_remap_pkg::DEST_DESER, alias_remap_pkg::DEST_TARGET}) begin
        d.fwd.stop = 1'b1;
      end
      d.st = S_IDLE;
      d.drive_low = 1'b0;
      d.dest = alias_remap_pkg::DEST_NONE;
    end else begin
      case (q.st)
        S_IDLE: begin
          d.drive_low = 1'b0;
        end
        S_ADDR, S_WR_BYTE: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], q.sda_s};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == alias_remap_pkg::BITS_PER_BYTE) begin
            d.bit_cnt = 4'h0;
            if (q.st == S_ADDR) begin
              // only the seven address bits take part in matching
              d.rw = q.shreg[0]; // RL14
              d.ptr_loaded = 1'b0;
              if (q.shreg[7:1] == LOCAL_ADDR) begin
                d.dest = alias_remap_pkg::DEST_LOCAL;
              end else if (alias_hit(q.shreg[7:1], q.deser_alias, q.deser_id)) begin
                d.dest = alias_remap_pkg::DEST_DESER; // RL1
                d.fwd.addr = q.deser_id[7:1]; // RL1
              end else if (alias_hit(q.shreg[7:1], q.target_alias, q.target_id)) begin
                d.dest = alias_remap_pkg::DEST_TARGET; // RL3
                d.fwd.addr = q.target_id[7:1]; // RL4
              end else begin
                d.dest = alias_remap_pkg::DEST_NONE; // RL2
              end
              if (d.dest == alias_remap_pkg::DEST_NONE) begin
                d.st = S_IDLE; // not ours: leave the line released
              end else begin
                d.st = S_ADDR_ACK;
                d.drive_low = 1'b1;
                if (d.dest != alias_remap_pkg::DEST_LOCAL) begin
                  d.fwd.start = 1'b1;
                  d.fwd.rw = q.shreg[0]; // RL14
                end
              end
            end else begin
              d.st = S_WR_ACK;
              d.drive_low = 1'b1;
              if (q.dest != alias_remap_pkg::DEST_LOCAL) begin
                d.fwd.data_valid = 1'b1; // RL4
                d.fwd.data = q.shreg;
              end else if (!q.ptr_loaded) begin
                d.ptr = q.shreg;
                d.ptr_loaded = 1'b1;
              end else begin
                // writes land at the pointer, then the pointer steps on
                case (q.ptr)
                  alias_remap_pkg::OFF_CTRL: d.ctrl = q.shreg;
                  alias_remap_pkg::OFF_DESER_ID: d.deser_id = q.shreg;
                  alias_remap_pkg::OFF_DESER_ALIAS: d.deser_alias = {q.shreg[7:1], 1'b0};
                  alias_remap_pkg::OFF_TARGET_ID: d.target_id = {q.shreg[7:1], 1'b0};
                  alias_remap_pkg::OFF_TARGET_ALIAS: d.target_alias = {q.shreg[7:1], 1'b0};
                  default: d.ctrl = q.ctrl; // read-only or unmapped: ignored
                endcase
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        S_ADDR_ACK, S_WR_ACK: begin
          // at the fall that ends the ack bit, release the line, or on a read drive the first data bit
          if (scl_fall) begin
            d.bit_cnt = 4'h0;
            if (q.rw && q.st == S_ADDR_ACK) begin
              d.st = S_RD_BYTE;
              d.shreg = (q.dest == alias_remap_pkg::DEST_LOCAL) ? reg_read(q, status_i) : remote_rdata_i;
              d.drive_low = ~d.shreg[7];
              d.bit_cnt = 4'h1;
            end else begin
              d.st = S_WR_BYTE;
              d.drive_low = 1'b0;
            end
          end
        end
        S_RD_BYTE: begin
          if (scl_fall) begin
            if (q.bit_cnt == alias_remap_pkg::BITS_PER_BYTE) begin
              d.st = S_RD_ACK;
              d.drive_low = 1'b0;
              if (q.dest == alias_remap_pkg::DEST_LOCAL) begin
                d.ptr = q.ptr + 8'h01;
              end
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.drive_low = ~q.shreg[6];
              d.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        S_RD_ACK: begin
          // master nack ends the read; ack fetches the next byte
          if (scl_rise) begin
            d.rw = ~q.sda_s;
          end else if (scl_fall) begin
            if (q.rw) begin
              d.st = S_RD_BYTE;
              d.shreg = (q.dest == alias_remap_pkg::DEST_LOCAL) ? reg_read(q, status_i) : remote_rdata_i;
              d.drive_low = ~d.shreg[7];
              d.bit_cnt = 4'h1;
            end else begin
              d.st = S_IDLE;
            end
          end
        end
        default: begin
          d.st = S_IDLE;
          d.drive_low = 1'b0;
        end
      endcase
    end

    // identifier auto-load after lock, unless software holds it
    if (status_i.rx_lock && remote_id_load_i && !d.deser_id[alias_remap_pkg::HOLD_ID_BIT]) begin
      d.deser_id[7:1] = remote_id_i; // RL12
    end

    // counter is held at zero for as long as the clear bit stays set
    if (q.ctrl[alias_remap_pkg::CTRL_CRC_CLR_BIT]) begin
      d.crc_count = alias_remap_pkg::RST_COUNT; // RL13
    end else if (backchannel_crc_err_i) begin
      d.crc_count = q.crc_count + 16'h0001; // RL5
    end

    // a fresh error wins over a clear in the same cycle
    if (remote_crc_err_i) begin
      d.remote_err = 1'b1; // RL9
    end else if (!status_i.link_detect || q.ctrl[alias_remap_pkg::CTRL_CRC_CLR_BIT]) begin
      d.remote_err = 1'b0; // RL10
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= S_IDLE;
      q.dest <= alias_remap_pkg::DEST_NONE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops; the pin only ever pulls low
  assign sda_o = q.sda_out;
  assign sda_oe_n_o = ~q.drive_low;
  assign fwd_o = q.fwd;

endmodule : i2c_alias_remap_status
